/* File: pkg/pct_pkg.sv */
// Purpose: Shared constants and types for the PWM and capture timer
// Assumes: 16-bit register port, one clock, offsets chosen by the design team
// Notes:   Register index equals the port address
package pct_pkg;

   localparam int unsigned CNT_W  = 16;
   localparam int unsigned N_CH   = 4;
   localparam int unsigned ADDR_W = 5;

   // Register addresses
   localparam logic [4:0] A_CTRL   = 5'h00;
   localparam logic [4:0] A_PSC    = 5'h01;
   localparam logic [4:0] A_ARR    = 5'h02;
   localparam logic [4:0] A_CNT    = 5'h03;
   localparam logic [4:0] A_CHMODE = 5'h04;
   localparam logic [4:0] A_DEAD   = 5'h05;
   localparam logic [4:0] A_STAT   = 5'h06;
   localparam logic [4:0] A_CLR    = 5'h07;
   localparam logic [4:0] A_IEN    = 5'h08;
   localparam logic [4:0] A_DEN    = 5'h09;
   localparam logic [4:0] A_CCR0   = 5'h0A;

   // Control fields
   localparam int unsigned C_EN     = 0;
   localparam int unsigned C_DIR0   = 1;
   localparam int unsigned C_OPM    = 3;
   localparam int unsigned C_DBGFRZ = 4;
   localparam int unsigned C_DBGOFF = 5;
   localparam int unsigned C_MOE    = 6;
   localparam int unsigned C_SLAVE  = 7;
   localparam int unsigned C_ENC    = 8;
   localparam int unsigned C_HALL   = 9;

   // Status fields: update, capture/compare per channel, trigger, hall change
   localparam int unsigned S_UPD  = 0;
   localparam int unsigned S_CC0  = 1;
   localparam int unsigned S_TRG  = 5;
   localparam int unsigned S_HALL = 6;
   localparam int unsigned ST_W   = 7;

   localparam logic [15:0] RST_ARR = 16'hFFFF;

   typedef enum logic [1:0] {
      PCT_UP   = 2'b00,
      PCT_DOWN = 2'b01,
      PCT_CTR  = 2'b10
   } pct_dir_e;

   typedef enum logic [1:0] {
      PCT_CAP = 2'b00,
      PCT_OC  = 2'b01,
      PCT_PWM = 2'b10
   } pct_chm_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [15:0]       wdata;
      logic              wr;
      logic              rd;
   } pct_bus_s;

endpackage : pct_pkg

/* File: rtl/pct_timer.sv */
// Purpose: 16-bit auto-reload timer with four channels, dead time and link
// Assumes: Pin inputs asynchronous; register port single-cycle, no wait
// Notes:   Channel 0..2 form the three complementary phase pairs
`timescale 1ns/1ps
// Overview of operation
// - 16-bit auto-reload counter counts up, down or up/down.
// - Prescaler divides the counter clock by any value 1 to 65536.
// - Four channels, each capture, compare or PWM; one-pulse mode stops the counter.
// - PWM edge-aligned or center-aligned.
// - Complementary output pairs with programmable dead time.
// - Three phases spread over six outputs.
// - Duty cycle spans zero to one hundred percent.
// - Debug halt can freeze the counter and force outputs inactive.
// - Timers link: trigger out and trigger in for sync or chaining.
// - Timer raises its own DMA requests.
// - Quadrature encoder input steps the counter.
// - One to three hall sensor inputs are sampled, changes flagged.
module pct_timer
   import pct_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // Register port
   input  wire pct_bus_s          bus,
   output logic [15:0]            rdata,
   // Pins
   input  wire logic [N_CH-1:0]   ch_in,
   input  wire logic [1:0]        enc_in,
   input  wire logic [2:0]        hall_in,
   input  wire logic              dbg_halt,
   input  wire logic              trig_in,
   output logic [N_CH-1:0]        ch_out,
   output logic [2:0]             ch_out_n,
   output logic                   trig_out,
   output logic                   dma_req,
   output logic                   irq
);

   logic [15:0] ctrl_q, ctrl_d, psc_q, psc_d, arr_q, arr_d, cnt_q, cnt_d;
   logic [15:0] pcnt_q, pcnt_d, chm_q, chm_d, dead_q, dead_d;
   logic [ST_W-1:0] st_q, st_d, ien_q, ien_d, den_q, den_d;
   logic [15:0] ccr_q [N_CH], ccr_d [N_CH];
   logic        down_q, down_d, tick;
   logic [15:0] rdata_d;
   // Synchronisers: stage 1 read only by stage 2
   logic [N_CH-1:0] ch_s1, ch_s2, ch_s3;
   logic [1:0]  enc_s1, enc_s2, enc_s3;
   logic [2:0]  hall_s1, hall_s2, hall_s3;
   logic        dbg_s1, dbg_s2, trg_s1, trg_s2, trg_s3;
   logic        upd, frozen, ext_trg;
   logic [ST_W-1:0] ev;
   logic [N_CH-1:0] ref_q, ref_d;
   logic [N_CH-1:0] out_d, out_q;
   logic [2:0]  outn_d, outn_q;
   logic [15:0] dt_q [3], dt_d [3];
   logic [2:0]  rdy_q, rdy_d;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ch_s1 <= '0; ch_s2 <= '0; ch_s3 <= '0;
         enc_s1 <= '0; enc_s2 <= '0; enc_s3 <= '0;
         hall_s1 <= '0; hall_s2 <= '0; hall_s3 <= '0;
         dbg_s1 <= 1'b0; dbg_s2 <= 1'b0;
         trg_s1 <= 1'b0; trg_s2 <= 1'b0; trg_s3 <= 1'b0;
      end else begin
         ch_s1 <= ch_in; ch_s2 <= ch_s1; ch_s3 <= ch_s2;
         enc_s1 <= enc_in; enc_s2 <= enc_s1; enc_s3 <= enc_s2;
         hall_s1 <= hall_in; hall_s2 <= hall_s1; hall_s3 <= hall_s2;
         dbg_s1 <= dbg_halt; dbg_s2 <= dbg_s1;
         trg_s1 <= trig_in; trg_s2 <= trg_s1; trg_s3 <= trg_s2;
      end
   end

   assign frozen  = dbg_s2 && ctrl_q[C_DBGFRZ];
   assign ext_trg = trg_s2 && !trg_s3;

   // Counter, prescaler and direction
   logic enc_step, enc_dir, cnt_en;
   always_comb begin
      ctrl_d = ctrl_q;
      pcnt_d = pcnt_q;
      cnt_d  = cnt_q;
      down_d = down_q;
      upd    = 1'b0;
      tick   = 1'b0;
      // Encoder: count on each edge of A, direction from A xor B
      enc_step = enc_s2[0] ^ enc_s3[0];
      enc_dir  = enc_s2[0] ^ enc_s2[1];
      cnt_en = ctrl_q[C_EN] && !frozen
               && (!ctrl_q[C_SLAVE] || ext_trg);
      if (cnt_en) begin
         if (pcnt_q == psc_q) begin
            pcnt_d = '0;
            tick   = 1'b1;
         end else begin
            pcnt_d = pcnt_q + 16'h0001;
         end
      end
      if (ctrl_q[C_ENC]) begin
         tick = ctrl_q[C_EN] && !frozen && enc_step;
         down_d = enc_dir;
      end
      if (tick) begin
         if (ctrl_q[C_ENC] ? enc_dir : down_q) begin
            if (cnt_q == 16'h0000) begin
               cnt_d = ctrl_q[C_ENC] ? arr_q : arr_q;
               upd   = 1'b1;
               if (ctrl_q[C_DIR0+:2] == PCT_CTR) begin
                  down_d = 1'b0;
                  cnt_d  = 16'h0001;
               end
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end else begin
            if (cnt_q >= arr_q) begin
               cnt_d = 16'h0000;
               upd   = 1'b1;
               if (ctrl_q[C_DIR0+:2] == PCT_CTR) begin
                  down_d = 1'b1;
                  cnt_d  = arr_q - 16'h0001;
               end
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         if (upd && ctrl_q[C_OPM]) ctrl_d[C_EN] = 1'b0;
      end
      if (!ctrl_q[C_ENC] && ctrl_q[C_DIR0+:2] != PCT_CTR)
         down_d = (ctrl_q[C_DIR0+:2] == PCT_DOWN);
      if (bus.wr && bus.addr == A_CTRL) ctrl_d = bus.wdata;
      if (bus.wr && bus.addr == A_CNT)  cnt_d  = bus.wdata;
      // A new divide factor restarts the prescaler, else a smaller one waits a full wrap
      if (bus.wr && bus.addr == A_PSC)  pcnt_d = 16'h0000;
   end

   // Channels: capture, compare, PWM reference
   always_comb begin
      ev = '0;
      ev[S_UPD] = upd;
      ev[S_TRG] = ext_trg;
      ev[S_HALL] = ctrl_q[C_HALL] && (hall_s2 != hall_s3);
      ref_d = ref_q;
      for (int i = 0; i < N_CH; i++) begin
         ccr_d[i] = ccr_q[i];
         case (pct_chm_e'(chm_q[4*i+:2]))
            PCT_CAP: begin
               // Edge select bit: 0 rising, 1 falling
               if (ch_s2[i] != ch_s3[i] && ch_s2[i] != chm_q[4*i+2]) begin
                  ccr_d[i] = cnt_q;
                  ev[S_CC0+i] = 1'b1;
               end
               ref_d[i] = 1'b0;
            end
            PCT_OC: begin
               if (tick && cnt_q == ccr_q[i]) begin
                  ref_d[i] = ~ref_q[i];
                  ev[S_CC0+i] = 1'b1;
               end
            end
            PCT_PWM: begin
               // Center mode uses the same compare both ways, giving symmetry
               ref_d[i] = (cnt_q < ccr_q[i]) ^ chm_q[4*i+3];
            end
            default: ref_d[i] = 1'b0;
         endcase
         if (bus.wr && bus.addr == A_CCR0 + 5'(i)) ccr_d[i] = bus.wdata;
      end
   end

   // Dead time per phase pair
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         dt_d[p]  = dt_q[p];
         rdy_d[p] = rdy_q[p];
         if (ref_d[p] != ref_q[p]) begin
            dt_d[p]  = dead_q;
            rdy_d[p] = (dead_q == 16'h0000);
         end else if (dt_q[p] != 16'h0000) begin
            dt_d[p]  = dt_q[p] - 16'h0001;
            rdy_d[p] = (dt_q[p] == 16'h0001);
         end
      end
      for (int i = 0; i < N_CH; i++) begin
         if (i < 3) out_d[i] = ref_d[i] && rdy_d[i];
         else       out_d[i] = ref_d[i];
      end
      for (int p = 0; p < 3; p++) outn_d[p] = !ref_d[p] && rdy_d[p];
      if (!ctrl_q[C_MOE] || (dbg_s2 && ctrl_q[C_DBGOFF])) begin
         out_d  = '0;
         outn_d = '0;
      end
   end

   // Status, enables, other registers and read mux
   always_comb begin
      psc_d  = psc_q;
      arr_d  = arr_q;
      chm_d  = chm_q;
      dead_d = dead_q;
      ien_d  = ien_q;
      den_d  = den_q;
      st_d   = st_q;
      if (bus.wr) begin
         case (bus.addr)
            A_PSC:    psc_d  = bus.wdata;
            A_ARR:    arr_d  = bus.wdata;
            A_CHMODE: chm_d  = bus.wdata;
            A_DEAD:   dead_d = bus.wdata;
            A_IEN:    ien_d  = bus.wdata[ST_W-1:0];
            A_DEN:    den_d  = bus.wdata[ST_W-1:0];
            A_CLR:    st_d   = st_q & ~bus.wdata[ST_W-1:0];
            default:  ;
         endcase
      end
      st_d = st_d | ev;
      rdata_d = 16'h0000;
      if (bus.rd) begin
         case (bus.addr)
            A_CTRL:   rdata_d = ctrl_q;
            A_PSC:    rdata_d = psc_q;
            A_ARR:    rdata_d = arr_q;
            A_CNT:    rdata_d = cnt_q;
            A_CHMODE: rdata_d = chm_q;
            A_DEAD:   rdata_d = dead_q;
            A_STAT:   rdata_d = {9'h000, st_q};
            A_IEN:    rdata_d = {9'h000, ien_q};
            A_DEN:    rdata_d = {9'h000, den_q};
            default: begin
               for (int i = 0; i < N_CH; i++)
                  if (bus.addr == A_CCR0 + 5'(i)) rdata_d = ccr_q[i];
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 16'h0000; psc_q <= 16'h0000; arr_q <= RST_ARR;
         cnt_q <= 16'h0000; pcnt_q <= 16'h0000; chm_q <= 16'h0000;
         dead_q <= 16'h0000; st_q <= '0; ien_q <= '0; den_q <= '0;
         down_q <= 1'b0; ref_q <= '0; out_q <= '0; outn_q <= '0;
         rdy_q <= 3'h7; rdata <= 16'h0000;
         for (int i = 0; i < N_CH; i++) ccr_q[i] <= 16'h0000;
         for (int p = 0; p < 3; p++) dt_q[p] <= 16'h0000;
         irq <= 1'b0; dma_req <= 1'b0; trig_out <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d; psc_q <= psc_d; arr_q <= arr_d;
         cnt_q <= cnt_d; pcnt_q <= pcnt_d; chm_q <= chm_d;
         dead_q <= dead_d; st_q <= st_d; ien_q <= ien_d; den_q <= den_d;
         down_q <= down_d; ref_q <= ref_d; out_q <= out_d; outn_q <= outn_d;
         rdy_q <= rdy_d; rdata <= rdata_d;
         for (int i = 0; i < N_CH; i++) ccr_q[i] <= ccr_d[i];
         for (int p = 0; p < 3; p++) dt_q[p] <= dt_d[p];
         irq <= |(st_d & ien_q);
         dma_req <= |(ev & den_q);
         trig_out <= upd;
      end
   end

   assign ch_out   = out_q;
   assign ch_out_n = outn_q;

   a_update_flag: assert property (@(posedge mclk) disable iff (rst)
      upd |=> st_q[S_UPD]) else $error("update event not flagged");
   // Qualifying edge on channel 0 with no software write to its register beside it
   sequence s_cap_edge;
      chm_q[1:0] == PCT_CAP && ch_s2[0] != ch_s3[0] && ch_s2[0] != chm_q[2]
      && !(bus.wr && bus.addr == A_CCR0);
   endsequence
   a_capture_val: assert property (@(posedge mclk) disable iff (rst)
      s_cap_edge |=> ccr_q[0] == $past(cnt_q)) else $error("capture value wrong");
   a_capture_flag: assert property (@(posedge mclk) disable iff (rst)
      s_cap_edge |=> st_q[S_CC0]) else $error("capture flag not set");
   a_dbg_freeze: assert property (@(posedge mclk) disable iff (rst)
      frozen && !(bus.wr && bus.addr == A_CNT) |=> $stable(cnt_q))
      else $error("counter moved while frozen");
   a_dbg_outoff: assert property (@(posedge mclk) disable iff (rst)
      dbg_s2 && ctrl_q[C_DBGOFF] |=> out_q == '0 && outn_q == '0)
      else $error("outputs active in debug");
   a_pair_excl: assert property (@(posedge mclk) disable iff (rst)
      (out_q[2:0] & outn_q) == 3'h0) else $error("pair overlap");
   a_up_reload: assert property (@(posedge mclk) disable iff (rst)
      tick && !down_q && !ctrl_q[C_ENC] && ctrl_q[C_DIR0+:2] == PCT_UP
      && cnt_q >= arr_q && !(bus.wr && bus.addr == A_CNT)
      |=> cnt_q == 16'h0000) else $error("up reload wrong");
   a_psc_period: assert property (@(posedge mclk) disable iff (rst)
      tick && !ctrl_q[C_ENC] |-> pcnt_q == psc_q) else $error("prescale tick early");
   a_irq_level: assert property (@(posedge mclk) disable iff (rst)
      (|(st_q & ien_q)) && $stable(ien_q) && !(bus.wr && bus.addr == A_CLR)
      |=> irq) else $error("irq missing");
   a_hall_flag: assert property (@(posedge mclk) disable iff (rst)
      ctrl_q[C_HALL] && hall_s2 != hall_s3 |=> st_q[S_HALL]) else $error("hall change lost");
   a_dma_event: assert property (@(posedge mclk) disable iff (rst)
      (|(ev & den_q)) |=> dma_req) else $error("dma request missing");
   a_trig_out: assert property (@(posedge mclk) disable iff (rst)
      upd |=> trig_out) else $error("trigger out missing");
   a_slave_gate: assert property (@(posedge mclk) disable iff (rst)
      ctrl_q[C_SLAVE] && !ctrl_q[C_ENC] && !ext_trg |-> !tick) else $error("slave counted early");

endmodule : pct_timer

/* File: dv/pct_field_model.sv */
// Purpose: Far side of the timer: encoder, hall sensors, capture source, switches
// Assumes: Bench commands are levels sampled on mclk
// Notes:   Any overlap on a phase pair is counted as shoot-through, never excused
`timescale 1ns/1ps
module pct_field_model (
   // Clock
   input  wire logic       mclk,
   // Bench commands
   input  wire logic       enc_go,
   input  wire logic       hall_go,
   input  wire logic       cap_go,
   // Timer pins
   input  wire logic [3:0] ch_out,
   input  wire logic [2:0] ch_out_n,
   output logic [3:0]      ch_in,
   output logic [1:0]      enc_in,
   output logic [2:0]      hall_in,
   output int              shoot
);
   logic [2:0] ph = 3'h0;
   initial begin
      ch_in = 4'h0;
      enc_in = 2'h0;
      hall_in = 3'h1;
      shoot = 0;
   end
   // Slow steps so the synchronisers see every level
   always @(posedge mclk) begin
      ph <= ph + 3'h1;
      if (enc_go && ph == 3'h0) enc_in <= {enc_in[0], ~enc_in[1]};
      if (hall_go && ph == 3'h0) hall_in <= {hall_in[1:0], hall_in[2]};
      ch_in[0] <= cap_go;
      if ((ch_out[2:0] & ch_out_n) != 3'h0) shoot <= shoot + 1;
   end
endmodule : pct_field_model

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for the PWM and capture timer
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Counter figures allow one count of slack for prescaler phase
`timescale 1ns/1ps
module tb_top;
   import pct_pkg::*;
   typedef struct {logic [4:0] a; logic [15:0] d; logic [15:0] e;} pct_row_s;
   logic        mclk = 1'b0, rst = 1'b1, dbg_halt = 1'b0, trig_in = 1'b0;
   logic        enc_go = 1'b0, hall_go = 1'b0, cap_go = 1'b0, dn, ok;
   pct_bus_s    bus = '0;
   logic [15:0] rdata, v, w, dd;
   logic [3:0]  ch_in, ch_out;
   logic [1:0]  enc_in;
   logic [2:0]  hall_in, ch_out_n;
   logic        trig_out, dma_req, irq;
   int          shoot, hi, hi_n, hx, hs, miscompares = 0, compares = 0, cyc = 0, n_dma, n_trg;
   pct_row_s    rows [10] = '{'{A_PSC, 16'hFFFF, 16'hFFFF}, '{A_PSC, 16'h0000, 16'h0000},
      '{A_ARR, 16'h1234, 16'h1234}, '{A_DEAD, 16'h0003, 16'h0003},
      '{A_CHMODE, 16'h2222, 16'h2222}, '{A_CCR0 + 5'h3, 16'hA5C3, 16'hA5C3},
      '{A_STAT, 16'h007F, 16'h0000}, '{A_CLR, 16'h007F, 16'h0000},
      '{5'h1F, 16'hFFFF, 16'h0000}, '{A_ARR, 16'hFFFF, 16'hFFFF}};

   pct_timer u_pct_timer (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .ch_in(ch_in),
      .enc_in(enc_in), .hall_in(hall_in), .dbg_halt(dbg_halt), .trig_in(trig_in),
      .ch_out(ch_out), .ch_out_n(ch_out_n), .trig_out(trig_out), .dma_req(dma_req), .irq(irq));
   pct_field_model u_pct_field_model (.mclk(mclk), .enc_go(enc_go), .hall_go(hall_go),
      .cap_go(cap_go), .ch_out(ch_out), .ch_out_n(ch_out_n), .ch_in(ch_in), .enc_in(enc_in),
      .hall_in(hall_in), .shoot(shoot));

   task automatic stop_test;
      if (miscompares == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus <= '0;
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus <= '0;
      #1 d = rdata;
   endtask : rd

   // Read samples are 200 cycles apart, so the delta is 200 / (psc + 1)
   task automatic rate(input logic [15:0] ctrl, input logic [15:0] psc, input logic [15:0] e);
      wr(A_CTRL, 16'h0);
      wr(A_PSC, psc);
      wr(A_CTRL, ctrl);
      rd(A_CNT, v);
      repeat (198) @(posedge mclk);
      rd(A_CNT, w);
      dd = ctrl[1] ? v - w : w - v;
      chk((dd - e + 16'h1 <= 16'h2) ? e : dd, e);
   endtask : rate

   // Sampled on the falling edge, away from output updates
   task automatic samp(input int n);
      hi = 0;
      hi_n = 0;
      hx = 0;
      repeat (n) begin
         @(negedge mclk);
         hi += ch_out[0];
         hi_n += ch_out_n[0];
         hx += $countones({ch_out[3:1], ch_out_n[2:1]});
      end
   endtask : samp

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   always @(negedge mclk) begin
      n_dma += dma_req;
      n_trg += trig_out;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      repeat (9) @(posedge mclk);
      #1 chk({6'h00, ch_out, ch_out_n, trig_out, dma_req, irq}, 16'h0000);
      @(posedge mclk);
      rst <= 1'b0;
      rd(A_CTRL, v);
      chk(v, 16'h0000);
      rd(A_CNT, v);
      chk(v, 16'h0000);
      rd(A_ARR, v);
      chk(v, RST_ARR);
      for (int i = 0; i < 10; i++) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         chk(v, rows[i].e);
      end
      rate(16'h0001, 16'h0000, 16'd200);
      rate(16'h0001, 16'h0003, 16'd50);
      rate(16'h0001, 16'hFFFF, 16'd0);
      rate(16'h0003, 16'h0000, 16'd200);
      // Center mode must stay inside 0..ARR and turn round
      wr(A_CTRL, 16'h0);
      wr(A_CNT, 16'h0);
      wr(A_ARR, 16'h0009);
      wr(A_CTRL, 16'h0005);
      v = 16'h0;
      dn = 1'b0;
      repeat (8) begin
         rd(A_CNT, w);
         chk({15'h0, w <= 16'h9}, 16'h1);
         dn |= (w < v);
         v = w;
      end
      chk({15'h0, dn}, 16'h1);
      wr(A_CTRL, 16'h0);
      wr(A_CNT, 16'h0);
      wr(A_CLR, 16'h007F);
      wr(A_DEN, 16'h0001);
      wr(A_IEN, 16'h0001);
      n_dma = 0;
      n_trg = 0;
      wr(A_CTRL, 16'h0001);
      repeat (40) @(posedge mclk);
      wr(A_CTRL, 16'h0);
      chk((n_dma >= 3 && n_dma <= 5) ? 16'h4 : 16'(n_dma), 16'h4);
      chk((n_trg >= 3 && n_trg <= 5) ? 16'h4 : 16'(n_trg), 16'h4);
      repeat (2) @(negedge mclk);
      chk({15'h0, irq}, 16'h1);
      wr(A_IEN, 16'h0);
      repeat (2) @(negedge mclk);
      chk({15'h0, irq}, 16'h0);
      wr(A_IEN, 16'h1);
      wr(A_CLR, 16'h1);
      repeat (2) @(negedge mclk);
      chk({15'h0, irq}, 16'h0);
      rd(A_STAT, v);
      chk(v & 16'h1, 16'h0);
      wr(A_CTRL, 16'h0009);
      repeat (30) @(posedge mclk);
      rd(A_CTRL, v);
      chk(v, 16'h0008);
      wr(A_CHMODE, 16'h0);
      wr(A_ARR, 16'hFFFF);
      wr(A_CLR, 16'h007F);
      wr(A_CTRL, 16'h0001);
      cap_go <= 1'b1;
      repeat (10) @(posedge mclk);
      rd(A_CCR0, v);
      rd(A_CNT, w);
      rd(A_STAT, dd);
      chk(dd & 16'h2, 16'h2);
      dd = w - v;
      chk((dd >= 16'd2 && dd <= 16'd16) ? 16'h1 : dd, 16'h1);
      // Falling-edge select: only the release of the input may flag now
      wr(A_CHMODE, 16'h0004);
      wr(A_CLR, 16'h007F);
      cap_go <= 1'b0;
      repeat (10) @(posedge mclk);
      rd(A_STAT, dd);
      chk(dd & 16'h0002, 16'h0002);
      wr(A_CTRL, 16'h0);
      wr(A_CNT, 16'h0);
      wr(A_ARR, 16'h0009);
      wr(A_DEAD, 16'h0002);
      wr(A_CHMODE, 16'h0002);
      wr(A_CCR0, 16'h0005);
      for (int m = 0; m < 2; m++) begin
         wr(A_CTRL, m ? 16'h0045 : 16'h0041);
         samp(200);
         // Two dead cycles per edge: 20 edge-aligned periods of 10, or 18-cycle centred ones
         hs = hi + hi_n;
         ok = hi >= 40 && hi_n >= 40 && (m ? hs >= 146 && hs <= 160 : hs >= 116 && hs <= 124);
         chk({15'h0000, ok}, 16'h0001);
      end
      chk(16'(shoot), 16'h0);
      wr(A_CTRL, 16'h0041);
      wr(A_CCR0, 16'h0000);
      samp(60);
      samp(40);
      chk(16'(hi), 16'h0);
      wr(A_CCR0, 16'h000A);
      samp(60);
      samp(40);
      chk(16'(hi * 256 + hi_n), 16'h2800);
      wr(A_CTRL, 16'h0071);
      dbg_halt <= 1'b1;
      repeat (5) @(posedge mclk);
      rd(A_CNT, v);
      repeat (20) @(posedge mclk);
      rd(A_CNT, w);
      chk(w, v);
      samp(10);
      chk(16'(hi + hi_n + hx), 16'h0000);
      dbg_halt <= 1'b0;
      wr(A_CTRL, 16'h0);
      wr(A_ARR, 16'hFFFF);
      wr(A_CTRL, 16'h0101);
      rd(A_CNT, v);
      enc_go <= 1'b1;
      repeat (128) @(posedge mclk);
      enc_go <= 1'b0;
      repeat (8) @(posedge mclk);
      rd(A_CNT, w);
      dd = w - v;
      chk((dd == 16'h8 || dd == 16'hFFF8) ? 16'h8 : dd, 16'h8);
      wr(A_CTRL, 16'h0201);
      wr(A_CLR, 16'h007F);
      hall_go <= 1'b1;
      repeat (16) @(posedge mclk);
      hall_go <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(A_STAT, v);
      chk(v & 16'h0040, 16'h0040);
      // Stepped slave: each rising trigger edge moves the counter by exactly one
      wr(A_CTRL, 16'h0);
      wr(A_CNT, 16'h0);
      wr(A_CLR, 16'h007F);
      wr(A_CTRL, 16'h0081);
      repeat (3) begin
         trig_in <= 1'b1;
         repeat (3) @(posedge mclk);
         trig_in <= 1'b0;
         repeat (3) @(posedge mclk);
      end
      repeat (4) @(posedge mclk);
      rd(A_CNT, v);
      chk(v, 16'h0003);
      rd(A_STAT, v);
      chk(v & 16'h0020, 16'h0020);
      // Compare toggle on all channels with no dead time: every level holds half the time
      wr(A_CTRL, 16'h0);
      wr(A_CNT, 16'h0);
      wr(A_ARR, 16'h0009);
      wr(A_DEAD, 16'h0);
      wr(A_CCR0, 16'h0003);
      wr(A_CCR0 + 5'h3, 16'h0003);
      wr(A_CHMODE, 16'h1111);
      wr(A_CLR, 16'h007F);
      wr(A_CTRL, 16'h0041);
      samp(20);
      samp(200);
      chk(16'(hi * 256 + hi_n), 16'h6464);
      chk(16'(hx), 16'h01F4);
      rd(A_STAT, v);
      chk(v & 16'h001E, 16'h001E);
      stop_test();
   end
endmodule : tb_top
